// file: rtl/fault_alert_status_regs.sv
// fault-alert status bank with axi4-lite register access
//
// Overview of operation
// - ground-return opens set bits five and four
// - ground/hv under/over flags wait until alert reset clears
// - headroom flag checked only during acquisition
// - bit zero ORs the enabled switch faults
// - switch summary refreshed when diagnostic scan ends
// - summary clears when resolved or written zero
// - write zero clears flag, one leaves it
// - writing one raises user alert to outputs
// - user alert clears on zero, resets low
// - mux fault needs mux enable, alert reset clear
// - mux clear honoured only once fault resolved
// - bit thirteen ORs enabled aux protection faults
// - aux alerts only for pins configured analog
// - aux summary clears with aux fault register
// - die hot sets bit twelve, stops balancing
// - bit eleven mirrors scan timeout field
// - scan timeout alert enabled when disable zero
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module fault_alert_status_regs
    import fault_alert_pkg::*;
#(
    parameter int SWITCH_COUNT = 14,
    parameter int AUX_COUNT    = 6,
    parameter int ADDR_WIDTH   = 8
) (
    input  wire logic                    clk_in,
    input  wire logic                    rst_b_in,
    // axi4-lite slave
    input  wire logic [ADDR_WIDTH-1:0]   s_axi_awaddr_in,
    input  wire logic                    s_axi_awvalid_in,
    output logic                         s_axi_awready_out,
    input  wire logic [31:0]             s_axi_wdata_in,
    input  wire logic [3:0]              s_axi_wstrb_in,
    input  wire logic                    s_axi_wvalid_in,
    output logic                         s_axi_wready_out,
    output logic [1:0]                   s_axi_bresp_out,
    output logic                         s_axi_bvalid_out,
    input  wire logic                    s_axi_bready_in,
    input  wire logic [ADDR_WIDTH-1:0]   s_axi_araddr_in,
    input  wire logic                    s_axi_arvalid_in,
    output logic                         s_axi_arready_out,
    output logic [31:0]                  s_axi_rdata_out,
    output logic [1:0]                   s_axi_rresp_out,
    output logic                         s_axi_rvalid_out,
    input  wire logic                    s_axi_rready_in,
    // analog detector levels, asynchronous
    input  wire logic                    ground_one_open_in,
    input  wire logic                    ground_two_open_in,
    input  wire logic                    hv_under_in,
    input  wire logic                    hv_over_in,
    input  wire logic                    hv_margin_low_in,
    input  wire logic                    die_hot_in,
    input  wire logic                    supply_mux_fault_in,
    input  wire logic [SWITCH_COUNT-1:0] per_switch_fault_in,
    input  wire logic [AUX_COUNT-1:0]    aux_protect_in,
    // same-clock status from the sequencers
    input  wire logic                    acquisition_active_in,
    input  wire logic                    switch_diag_done_in,
    input  wire logic                    balancing_active_in,
    input  wire logic                    scan_timeout_event_in,
    // alert and balancing outputs
    output logic                         alert_out,
    output logic                         link_status_alert_out,
    output logic                         irq_out,
    output logic                         balancing_stop_out,
    output logic [1:0]                   balancing_activity_code_out
);
    if (SWITCH_COUNT < 1 || SWITCH_COUNT > 16 || AUX_COUNT < 1 || AUX_COUNT > 16
        || ADDR_WIDTH < 8) begin : g_check
        $error("fault_alert_status_regs: unsupported parameter value");
    end

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic                    aw_held;
        logic [5:0]              aw_idx;
        logic                    w_held;
        logic [15:0]             wdata;
        logic [1:0]              wstrb;
        logic                    bvalid;
        logic [1:0]              bresp;
        logic                    rvalid;
        logic [15:0]             rdata;
        logic [1:0]              rresp;
        logic [PIN_COUNT-1:0]    meta_pin;
        logic [PIN_COUNT-1:0]    sync_pin;
        logic [SWITCH_COUNT-1:0] meta_sw;
        logic [SWITCH_COUNT-1:0] sync_sw;
        logic [AUX_COUNT-1:0]    meta_aux;
        logic [AUX_COUNT-1:0]    sync_aux;
        logic [5:0]              fault_one;
        logic                    user_test_alert;
        logic                    supply_mux_fault;
        logic                    die_hot_flag;
        logic                    scan_timeout_field;
        logic                    alert_reset_status;
        logic                    flex_mux_enable;
        logic                    scan_timeout_disable;
        logic [SWITCH_COUNT-1:0] switch_enable;
        logic [AUX_COUNT-1:0]    aux_config;
        logic [AUX_COUNT-1:0]    aux_protect_faults;
        logic                    balancing_thermal_stop;
        logic                    stop_pulse;
        logic [IRQ_BITS-1:0]     irq_status;
        logic [IRQ_BITS-1:0]     irq_mask;
        logic                    alert;
    } state_type;

    state_type s;
    state_type next_s;

    logic                    wr_fire;
    logic [15:0]             wr_en;
    logic [15:0]             wr_clr;
    logic [15:0]             wr_set;
    logic                    rd_fire;
    logic [5:0]              rd_idx;
    logic [15:0]             rd_value;
    logic                    rd_hit;
    logic                    wr_hit;
    logic [15:0]             fault_two;
    logic                    sw_any;
    logic                    aux_sum;
    logic [5:0]              f1_set;
    logic                    hot_stop;

    // ------------------------------------------------------------------
    // combinational views
    // ------------------------------------------------------------------
    assign s_axi_awready_out = !s.aw_held;
    assign s_axi_wready_out  = !s.w_held;
    assign s_axi_arready_out = !s.rvalid;
    assign wr_fire = s.aw_held && s.w_held && !s.bvalid;
    assign rd_fire = s_axi_arvalid_in && !s.rvalid;
    assign rd_idx  = s_axi_araddr_in[7:2];
    assign wr_en   = {{8{s.wstrb[1]}}, {8{s.wstrb[0]}}};
    assign wr_clr  = wr_en & ~s.wdata;
    assign wr_set  = wr_en & s.wdata;

    assign sw_any  = |(s.sync_sw & s.switch_enable);
    assign aux_sum = |(s.aux_protect_faults & s.aux_config);
    assign hot_stop = s.sync_pin[PIN_DIE_HOT] && balancing_active_in
                      && !s.balancing_thermal_stop;

    always_comb begin
        fault_two = 16'h0000;
        fault_two[F2_USER]    = s.user_test_alert;
        fault_two[F2_MUX]     = s.supply_mux_fault;
        fault_two[F2_AUX_SUM] = aux_sum;
        fault_two[F2_DIE_HOT] = s.die_hot_flag;
        fault_two[F2_SCAN_TO] = s.scan_timeout_field;
    end

    function automatic logic hit(input logic [5:0] idx);
        hit = idx == IDX_FAULT_ONE || idx == IDX_FAULT_TWO || idx == IDX_CONTROL
              || idx == IDX_SCAN_CTRL || idx == IDX_SWITCH_EN || idx == IDX_AUX_CFG
              || idx == IDX_AUX_FAULTS || idx == IDX_BAL_STATUS
              || idx == IDX_IRQ_STATUS || idx == IDX_IRQ_MASK;
    endfunction : hit

    assign rd_hit = hit(rd_idx);
    assign wr_hit = hit(s.aw_idx);

    always_comb begin
        rd_value = 16'h0000;
        unique case (rd_idx)
            IDX_FAULT_ONE:  rd_value = {10'h000, s.fault_one};
            IDX_FAULT_TWO:  rd_value = fault_two;
            IDX_CONTROL:    rd_value = {13'h0000, s.scan_timeout_disable,
                                        s.flex_mux_enable, s.alert_reset_status};
            IDX_SCAN_CTRL:  rd_value = {15'h0000, s.scan_timeout_field};
            IDX_SWITCH_EN:  rd_value = 16'(s.switch_enable);
            IDX_AUX_CFG:    rd_value = 16'(s.aux_config);
            IDX_AUX_FAULTS: rd_value = 16'(s.aux_protect_faults);
            IDX_BAL_STATUS: rd_value = {13'h0000, balancing_activity_code_out,
                                        s.balancing_thermal_stop};
            IDX_IRQ_STATUS: rd_value = 16'(s.irq_status);
            IDX_IRQ_MASK:   rd_value = 16'(s.irq_mask);
            default:        rd_value = 16'h0000;
        endcase
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        next_s = s;
        // bus write channel capture
        if (s_axi_awvalid_in && !s.aw_held) begin
            next_s.aw_held = 1'b1;
            next_s.aw_idx  = s_axi_awaddr_in[7:2];
        end
        if (s_axi_wvalid_in && !s.w_held) begin
            next_s.w_held = 1'b1;
            next_s.wdata  = s_axi_wdata_in[15:0];
            next_s.wstrb  = s_axi_wstrb_in[1:0];
        end
        if (s.bvalid && s_axi_bready_in) begin
            next_s.bvalid = 1'b0;
        end
        if (wr_fire) begin
            next_s.aw_held = 1'b0;
            next_s.w_held  = 1'b0;
            next_s.bvalid  = 1'b1;
            next_s.bresp   = wr_hit ? RESP_OKAY : RESP_SLVERR;
        end
        // bus read channel
        if (s.rvalid && s_axi_rready_in) begin
            next_s.rvalid = 1'b0;
        end
        if (rd_fire) begin
            next_s.rvalid = 1'b1;
            next_s.rdata  = rd_hit ? rd_value : 16'h0000;
            next_s.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        // two-stage synchronisers
        next_s.meta_pin = {supply_mux_fault_in, die_hot_in, hv_margin_low_in, hv_over_in,
                           hv_under_in, ground_two_open_in, ground_one_open_in};
        next_s.sync_pin = s.meta_pin;
        next_s.meta_sw  = per_switch_fault_in;
        next_s.sync_sw  = s.meta_sw;
        next_s.meta_aux = aux_protect_in;
        next_s.sync_aux = s.meta_aux;

        // software clears and plain register writes; hardware sets follow and win
        if (wr_fire) begin
            unique case (s.aw_idx)
                IDX_FAULT_ONE: begin
                    next_s.fault_one = s.fault_one & ~wr_clr[5:0];
                end
                IDX_FAULT_TWO: begin
                    if (wr_en[F2_USER]) begin
                        next_s.user_test_alert = s.wdata[F2_USER];
                    end
                    if (wr_clr[F2_MUX] && !s.sync_pin[PIN_MUX]) begin
                        next_s.supply_mux_fault = 1'b0;
                    end
                    if (wr_clr[F2_DIE_HOT]) begin
                        next_s.die_hot_flag = 1'b0;
                    end
                end
                IDX_CONTROL: begin
                    if (wr_clr[CT_ALERT_RST]) begin
                        next_s.alert_reset_status = 1'b0;
                    end
                    if (wr_en[CT_FLEX_MUX]) begin
                        next_s.flex_mux_enable = s.wdata[CT_FLEX_MUX];
                    end
                    if (wr_en[CT_TO_DIS]) begin
                        next_s.scan_timeout_disable = s.wdata[CT_TO_DIS];
                    end
                end
                IDX_SCAN_CTRL: begin
                    if (wr_clr[0]) begin
                        next_s.scan_timeout_field = 1'b0;
                    end
                end
                IDX_SWITCH_EN: begin
                    next_s.switch_enable = (s.switch_enable & ~wr_en[SWITCH_COUNT-1:0])
                                         | wr_set[SWITCH_COUNT-1:0];
                end
                IDX_AUX_CFG: begin
                    next_s.aux_config = (s.aux_config & ~wr_en[AUX_COUNT-1:0])
                                      | wr_set[AUX_COUNT-1:0];
                end
                IDX_AUX_FAULTS: begin
                    next_s.aux_protect_faults = s.aux_protect_faults
                                              & ~wr_clr[AUX_COUNT-1:0];
                end
                IDX_BAL_STATUS: begin
                    if (wr_clr[0]) begin
                        next_s.balancing_thermal_stop = 1'b0;
                    end
                end
                IDX_IRQ_STATUS: begin
                    next_s.irq_status = s.irq_status & ~wr_set[IRQ_BITS-1:0];
                end
                IDX_IRQ_MASK: begin
                    next_s.irq_mask = (s.irq_mask & ~wr_en[IRQ_BITS-1:0])
                                    | wr_set[IRQ_BITS-1:0];
                end
                default: begin
                end
            endcase
        end

        // hardware sets of fault_alert_one
        f1_set = 6'h00;
        if (!s.alert_reset_status) begin
            f1_set[F1_GND_TWO]  = s.sync_pin[PIN_GND_TWO];
            f1_set[F1_GND_ONE]  = s.sync_pin[PIN_GND_ONE];
            f1_set[F1_HV_UNDER] = s.sync_pin[PIN_HV_UNDER];
            f1_set[F1_HV_OVER]  = s.sync_pin[PIN_HV_OVER];
        end
        f1_set[F1_HV_MARGIN] = s.sync_pin[PIN_MARGIN] && acquisition_active_in;
        next_s.fault_one = next_s.fault_one | f1_set;
        if (switch_diag_done_in) begin
            next_s.fault_one[F1_SW_SUM] = sw_any;
        end else if (!sw_any) begin
            next_s.fault_one[F1_SW_SUM] = 1'b0;
        end

        // hardware sets of fault_alert_two
        if (s.flex_mux_enable && !s.alert_reset_status && s.sync_pin[PIN_MUX]) begin
            next_s.supply_mux_fault = 1'b1;
        end
        if (s.sync_pin[PIN_DIE_HOT]) begin
            next_s.die_hot_flag = 1'b1;
        end
        if (scan_timeout_event_in && !s.scan_timeout_disable) begin
            next_s.scan_timeout_field = 1'b1;
        end
        next_s.aux_protect_faults = next_s.aux_protect_faults
                                  | (s.sync_aux & s.aux_config);

        // thermal stop of balancing
        next_s.stop_pulse = hot_stop;
        if (hot_stop) begin
            next_s.balancing_thermal_stop = 1'b1;
        end

        // interrupt events, set wins over clear
        next_s.irq_status[IRQ_ONE]     = next_s.irq_status[IRQ_ONE] | (|(f1_set & ~s.fault_one));
        next_s.irq_status[IRQ_TWO]     = next_s.irq_status[IRQ_TWO]
                                       | (next_s.die_hot_flag & ~s.die_hot_flag)
                                       | (next_s.supply_mux_fault & ~s.supply_mux_fault)
                                       | (next_s.scan_timeout_field & ~s.scan_timeout_field);
        next_s.irq_status[IRQ_THERMAL] = next_s.irq_status[IRQ_THERMAL] | hot_stop;

        next_s.alert = (|next_s.fault_one) | next_s.user_test_alert | next_s.supply_mux_fault
                     | next_s.die_hot_flag | next_s.scan_timeout_field
                     | (|(next_s.aux_protect_faults & next_s.aux_config));
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s <= '0;
            s.alert_reset_status <= 1'b1;
            s.switch_enable      <= SWITCH_EN_RESET[SWITCH_COUNT-1:0];
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign s_axi_bvalid_out = s.bvalid;
    assign s_axi_bresp_out  = s.bresp;
    assign s_axi_rvalid_out = s.rvalid;
    assign s_axi_rdata_out  = {16'h0000, s.rdata};
    assign s_axi_rresp_out  = s.rresp;
    assign alert_out             = s.alert;
    assign link_status_alert_out = s.alert;
    assign irq_out               = |(s.irq_status & s.irq_mask);
    assign balancing_stop_out    = s.stop_pulse;
    assign balancing_activity_code_out = s.balancing_thermal_stop ? CODE_THERMAL :
                                         (balancing_active_in ? CODE_ACTIVE : CODE_IDLE);

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    property p_ground_set;
        s.sync_pin[PIN_GND_TWO] && !s.alert_reset_status |=> s.fault_one[F1_GND_TWO];
    endproperty
    a_ground_set: assert property (p_ground_set) else $error("ground open flag not set");

    property p_alert_reset_gate;
        s.alert_reset_status && !s.fault_one[F1_HV_UNDER] |=> !s.fault_one[F1_HV_UNDER];
    endproperty
    a_alert_reset_gate: assert property (p_alert_reset_gate)
        else $error("undervoltage flag set during alert reset");

    property p_margin_gate;
        !acquisition_active_in && !s.fault_one[F1_HV_MARGIN] |=> !s.fault_one[F1_HV_MARGIN];
    endproperty
    a_margin_gate: assert property (p_margin_gate) else $error("headroom flag set outside acquisition");

    property p_switch_summary;
        switch_diag_done_in |=> s.fault_one[F1_SW_SUM] == $past(sw_any);
    endproperty
    a_switch_summary: assert property (p_switch_summary) else $error("switch summary not refreshed");

    property p_write_one_keeps;
        wr_fire && s.aw_idx == IDX_FAULT_ONE && s.wstrb[0] && s.wdata[F1_GND_ONE]
            && s.fault_one[F1_GND_ONE] |=> s.fault_one[F1_GND_ONE];
    endproperty
    a_write_one_keeps: assert property (p_write_one_keeps) else $error("write one changed flag");

    property p_user_alert;
        wr_fire && s.aw_idx == IDX_FAULT_TWO && s.wstrb[1] && s.wdata[F2_USER]
            |=> s.user_test_alert && alert_out && link_status_alert_out;
    endproperty
    a_user_alert: assert property (p_user_alert) else $error("user alert not forwarded");

    property p_mux_hold;
        s.supply_mux_fault && s.sync_pin[PIN_MUX] |=> s.supply_mux_fault;
    endproperty
    a_mux_hold: assert property (p_mux_hold) else $error("mux fault cleared while present");

    property p_scan_timeout;
        scan_timeout_event_in && !s.scan_timeout_disable |=> s.scan_timeout_field;
    endproperty
    a_scan_timeout: assert property (p_scan_timeout) else $error("scan timeout not flagged");

    property p_thermal_stop;
        hot_stop |=> balancing_stop_out && balancing_activity_code_out == CODE_THERMAL
            ##1 !balancing_stop_out;
    endproperty
    a_thermal_stop: assert property (p_thermal_stop) else $error("thermal stop not reported");

    property p_unused_zero;
        rd_fire && rd_idx == IDX_FAULT_TWO |=> s_axi_rvalid_out && s_axi_rdata_out[10:0] == 11'h000;
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused fault bits not zero");

    c_write_fault_two: cover property (wr_fire && s.aw_idx == IDX_FAULT_TWO);
    c_thermal_stop:    cover property (hot_stop);
    c_irq_raised:      cover property (!irq_out ##1 irq_out);
endmodule : fault_alert_status_regs
`default_nettype wire

// file: rtl/fault_alert_pkg.sv
// register map, field positions and reset values of the fault-alert bank
package fault_alert_pkg;
    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_FAULT_ONE   = 6'h05;
    localparam logic [5:0] IDX_FAULT_TWO   = 6'h06;
    localparam logic [5:0] IDX_CONTROL     = 6'h08;
    localparam logic [5:0] IDX_SCAN_CTRL   = 6'h09;
    localparam logic [5:0] IDX_SWITCH_EN   = 6'h0a;
    localparam logic [5:0] IDX_AUX_CFG     = 6'h0b;
    localparam logic [5:0] IDX_AUX_FAULTS  = 6'h0c;
    localparam logic [5:0] IDX_BAL_STATUS  = 6'h0d;
    localparam logic [5:0] IDX_IRQ_STATUS  = 6'h0e;
    localparam logic [5:0] IDX_IRQ_MASK    = 6'h0f;
    // fault_alert_one fields
    localparam int F1_GND_TWO   = 5;
    localparam int F1_GND_ONE   = 4;
    localparam int F1_HV_UNDER  = 3;
    localparam int F1_HV_MARGIN = 2;
    localparam int F1_HV_OVER   = 1;
    localparam int F1_SW_SUM    = 0;
    // fault_alert_two fields
    localparam int F2_USER      = 15;
    localparam int F2_MUX       = 14;
    localparam int F2_AUX_SUM   = 13;
    localparam int F2_DIE_HOT   = 12;
    localparam int F2_SCAN_TO   = 11;
    // control register fields
    localparam int CT_ALERT_RST = 0;
    localparam int CT_FLEX_MUX  = 1;
    localparam int CT_TO_DIS    = 2;
    // interrupt status / mask fields
    localparam int IRQ_BITS     = 3;
    localparam int IRQ_ONE      = 0;
    localparam int IRQ_TWO      = 1;
    localparam int IRQ_THERMAL  = 2;
    // synchronised detector pin positions
    localparam int PIN_COUNT    = 7;
    localparam int PIN_GND_ONE  = 0;
    localparam int PIN_GND_TWO  = 1;
    localparam int PIN_HV_UNDER = 2;
    localparam int PIN_HV_OVER  = 3;
    localparam int PIN_MARGIN   = 4;
    localparam int PIN_DIE_HOT  = 5;
    localparam int PIN_MUX      = 6;
    // reset values and codes
    localparam logic [15:0] SWITCH_EN_RESET = 16'h3fff;
    localparam logic [1:0]  CODE_IDLE       = 2'h0;
    localparam logic [1:0]  CODE_ACTIVE     = 2'h1;
    localparam logic [1:0]  CODE_THERMAL    = 2'h3;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage : fault_alert_pkg

// file: bench/fault_alert_status_regs_tb_top.sv
// self-checking bench for the fault-alert status bank
`timescale 1ns/100ps
`default_nettype none
module fault_alert_status_regs_tb_top
    import fault_alert_pkg::*;
;
    logic        clk, rst_b, awv, wv, bre, arv, rre, awr, wr, bv, arr, rv, irq, alrt, lalrt;
    logic        g1, g2, hvu, hvo, mrg, hot, sto, done;
    logic [7:0]  awa, ara;
    logic [31:0] wd, rd;
    logic [1:0]  br, rr;
    logic [13:0] sw;
    logic        mux, acq, bal, bstop;
    logic [1:0]  bcode;
    logic [5:0]  aux;
    logic [17:0] exq[$];
    int          fails = 0, n_tests = 0, nstop = 0;
    fault_alert_status_regs u_fault_alert_status_regs (.clk_in(clk), .rst_b_in(rst_b),
        .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
        .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wv), .s_axi_wready_out(wr),
        .s_axi_bresp_out(br), .s_axi_bvalid_out(bv), .s_axi_bready_in(bre),
        .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
        .s_axi_rdata_out(rd), .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv), .s_axi_rready_in(rre),
        .ground_one_open_in(g1), .ground_two_open_in(g2), .hv_under_in(hvu), .hv_over_in(hvo),
        .hv_margin_low_in(mrg), .die_hot_in(hot), .supply_mux_fault_in(mux),
        .per_switch_fault_in(sw), .aux_protect_in(aux), .acquisition_active_in(acq),
        .switch_diag_done_in(done), .balancing_active_in(bal), .scan_timeout_event_in(sto),
        .alert_out(alrt), .link_status_alert_out(lalrt), .irq_out(irq),
        .balancing_stop_out(bstop), .balancing_activity_code_out(bcode));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : give_verdict
    task automatic check(input string nm, input logic [17:0] e, input logic [17:0] s);
        n_tests++;
        if (e !== s) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask : check
    task automatic timeout(input int n);
        if (n >= 50) begin
            fails++;
            give_verdict();
        end
    endtask : timeout
    task automatic wr_reg(input logic [5:0] idx, input logic [15:0] d);
        int n = 0;
        awa <= {idx, 2'b00}; wd <= {16'h0000, d}; awv <= 1'b1; wv <= 1'b1;
        do begin
            @(posedge clk); n++;
            if (awv && awr) awv <= 1'b0;
            if (wv && wr) wv <= 1'b0;
        end while (!bv && n < 50);
        timeout(n);
    endtask : wr_reg
    task automatic rd_reg(input logic [5:0] idx, input logic [15:0] e, input logic [1:0] r);
        int n = 0;
        exq.push_back({r, e});
        ara <= {idx, 2'b00}; arv <= 1'b1;
        do begin @(posedge clk); n++; end while (!arr && n < 50);
        arv <= 1'b0;
        do begin @(posedge clk); n++; end while (!rv && n < 50);
        timeout(n);
    endtask : rd_reg
    // ------------------------------------------------------------
    // read-data watcher
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (rv && rre) check("rdata", exq.pop_front(), {rr, rd[15:0]});
        if (bstop === 1'b1) nstop++;
    end
    initial begin
        {rst_b, awv, wv, bre, arv, rre, g1, g2, hvu, hvo, mrg, hot, sto, done} = '0;
        {mux, acq, bal} = '0;
        {awa, ara, wd, sw, aux} = '0;
        void'($urandom(89507));
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        {bre, rre} <= 2'b11;
        @(posedge clk);
        rd_reg(IDX_FAULT_TWO, 16'h0000, RESP_OKAY);
        {g1, g2, hvu, hvo, mrg} <= 5'h1f;
        repeat (6) @(posedge clk);
        rd_reg(IDX_FAULT_ONE, 16'h0000, RESP_OKAY);
        wr_reg(IDX_IRQ_MASK, 16'h0001);
        wr_reg(IDX_CONTROL, 16'h0000);
        repeat (5) @(posedge clk);
        rd_reg(IDX_FAULT_ONE, 16'h003a, RESP_OKAY);
        check("irq_out", 18'h1, {17'h0, irq});
        acq <= 1'b1;
        repeat (5) @(posedge clk);
        rd_reg(IDX_FAULT_ONE, 16'h003e, RESP_OKAY);
        {g1, g2, hvu, hvo, mrg, acq} <= 6'h00;
        repeat (4) @(posedge clk);
        wr_reg(IDX_FAULT_ONE, 16'hffff);
        rd_reg(IDX_FAULT_ONE, 16'h003e, RESP_OKAY);
        wr_reg(IDX_FAULT_ONE, 16'h0000);
        wr_reg(IDX_IRQ_STATUS, 16'h0007);
        rd_reg(IDX_FAULT_ONE, 16'h0000, RESP_OKAY);
        check("irq_out", 18'h0, {17'h0, irq});
        wr_reg(IDX_FAULT_TWO, 16'h87f0);
        rd_reg(IDX_FAULT_TWO, 16'h8000, RESP_OKAY);
        check("alerts", 18'h3, {16'h0, alrt, lalrt});
        wr_reg(IDX_FAULT_TWO, 16'h0000);
        rd_reg(IDX_FAULT_TWO, 16'h0000, RESP_OKAY);
        sw <= 14'($urandom) | 14'h0001;
        repeat (5) @(posedge clk);
        rd_reg(IDX_FAULT_ONE, 16'h0000, RESP_OKAY);
        done <= 1'b1;
        @(posedge clk);
        done <= 1'b0;
        rd_reg(IDX_FAULT_ONE, 16'h0001, RESP_OKAY);
        sw <= 14'h0000;
        repeat (5) @(posedge clk);
        rd_reg(IDX_FAULT_ONE, 16'h0000, RESP_OKAY);
        rd_reg(6'h3f, 16'h0000, RESP_SLVERR);
        // mux and aux pins high while mux is off and no pin is analog
        {mux, aux} <= 7'h7f;
        repeat (5) @(posedge clk);
        rd_reg(IDX_FAULT_TWO, 16'h0000, RESP_OKAY);
        wr_reg(IDX_CONTROL, 16'h0002);
        wr_reg(IDX_AUX_CFG, 16'h0001);
        wr_reg(IDX_FAULT_TWO, 16'h0000);
        rd_reg(IDX_FAULT_TWO, 16'h6000, RESP_OKAY);
        {mux, aux} <= 7'h00;
        repeat (4) @(posedge clk);
        wr_reg(IDX_FAULT_TWO, 16'h0000);
        wr_reg(IDX_AUX_FAULTS, 16'h0000);
        rd_reg(IDX_FAULT_TWO, 16'h0000, RESP_OKAY);
        {sto, hot, bal} <= 3'b111;
        @(posedge clk);
        {sto, hot} <= 2'b00;
        repeat (5) @(posedge clk);
        rd_reg(IDX_FAULT_TWO, 16'h1800, RESP_OKAY);
        check("activity_code", 18'h3, {16'h0, bcode});
        check("stop_pulses", 18'h1, 18'(nstop));
        wr_reg(IDX_FAULT_TWO, 16'h0000);
        wr_reg(IDX_SCAN_CTRL, 16'h0000);
        rd_reg(IDX_FAULT_TWO, 16'h0000, RESP_OKAY);
        give_verdict();
    end
endmodule : fault_alert_status_regs_tb_top
`default_nettype wire
